// ==== src/adccc_top.sv ====
// converter launch, averaging and result registers
`default_nettype none
`include "adccc_regs.svh"
//
// Contract
// - writing one to launch bit while idle starts sequence
// - launch bit stays set, self-clears when done
// - average field selects two-power measurement count
// - channel field selects converter input node
// - mean of measurements goes to mean register
// - smallest measurement goes to lowest register
// - largest measurement goes to highest register
module adccc_top import adccc_pkg::*; #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_write,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  // analog converter handshake
  output logic                   conv_request,
  output logic [2:0]             conv_channel,
  input  wire logic              conv_done,
  input  wire logic [DATA_W-1:0] conv_data,
  // status
  output logic                   busy
);
  adccc_state_e            state;
  adccc_state_e            next_state;
  logic                    launch;
  logic                    next_launch;
  logic [5:0]              setup;
  logic [5:0]              next_setup;
  logic [7:0]              remain;
  logic [7:0]              next_remain;
  logic [7:0]              mean;
  logic [7:0]              next_mean;
  logic [7:0]              lowest_q;
  logic [7:0]              next_lowest_q;
  logic [7:0]              highest_q;
  logic [7:0]              next_highest_q;
  logic [`ADCCC_SUM_W-1:0] sum;
  logic [DATA_W-1:0]       run_low;
  logic [DATA_W-1:0]       run_high;
  logic                    start_wr;
  logic                    setup_wr;
  logic [2:0]              avg_code;
  logic [2:0]              wr_chan;

  // write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign start_wr = reg_write && hit(reg_addr, `ADCCC_OFS_START)
                    && reg_wdata[`ADCCC_LAUNCH_BIT];
  assign setup_wr = reg_write && hit(reg_addr, `ADCCC_OFS_SETUP);
  assign avg_code = setup[`ADCCC_AVG_MSB:`ADCCC_AVG_LSB];
  assign conv_channel = setup[`ADCCC_CHAN_MSB:`ADCCC_CHAN_LSB];
  assign wr_chan = reg_wdata[`ADCCC_CHAN_MSB:`ADCCC_CHAN_LSB]; // write field
  assign busy = launch;

  // running statistics, restarted by an accepted launch write
  adccc_stats #(.DATA_W(DATA_W)) u_stats (
    .clock        (clock),
    .reset        (reset),
    .clear        (start_wr && state == ADCCC_IDLE),
    .sample_valid (conv_done && state == ADCCC_WAIT),
    .sample       (conv_data),
    .sum          (sum),
    .lowest       (run_low),
    .highest      (run_high)
  );

  // sequencer next values
  always_comb begin
    next_state     = state;
    next_launch    = launch;
    next_setup     = setup;
    next_remain    = remain;
    next_mean      = mean;
    next_lowest_q  = lowest_q;
    next_highest_q = highest_q;
    conv_request   = 1'b0;
    if (setup_wr) next_setup = reg_wdata[`ADCCC_AVG_MSB:`ADCCC_CHAN_LSB];
    case (state)
      // idle: wait for a launch write
      ADCCC_IDLE: begin
        if (start_wr) begin
          next_launch = 1'b1;
          next_remain = 8'(1 << avg_code);
          next_state  = ADCCC_WAIT;
        end
      end
      // wait: one measurement per done pulse
      ADCCC_WAIT: begin
        conv_request = 1'b1;
        if (conv_done) begin
          next_remain = remain - 8'h01;
          if (remain == 8'h01) next_state = ADCCC_DONE;
        end
      end
      // done: load results and release the launch bit
      ADCCC_DONE: begin
        next_mean      = 8'(sum >> avg_code);
        next_lowest_q  = 8'(run_low);
        next_highest_q = 8'(run_high);
        next_launch    = 1'b0;
        next_state     = ADCCC_IDLE;
      end
      default: begin
        next_state  = ADCCC_IDLE;
        next_launch = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state     <= ADCCC_IDLE;
      launch    <= 1'b0;
      setup     <= 6'(`ADCCC_RST_BYTE);
      remain    <= 8'h00;
      mean      <= `ADCCC_RST_BYTE;
      lowest_q  <= `ADCCC_RST_BYTE;
      highest_q <= `ADCCC_RST_BYTE;
    end else begin
      state     <= next_state;
      launch    <= next_launch;
      setup     <= next_setup;
      remain    <= next_remain;
      mean      <= next_mean;
      lowest_q  <= next_lowest_q;
      highest_q <= next_highest_q;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    case (reg_addr)
      `ADCCC_OFS_START:   reg_rdata = {7'h00, launch};
      `ADCCC_OFS_SETUP:   reg_rdata = {2'h0, setup};
      `ADCCC_OFS_MEAN:    reg_rdata = mean;
      `ADCCC_OFS_LOWEST:  reg_rdata = lowest_q;
      `ADCCC_OFS_HIGHEST: reg_rdata = highest_q;
      default:            reg_rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence launch_write_s;
    state == ADCCC_IDLE && start_wr;
  endsequence

  // last measurement of a sequence, then the two completion steps
  sequence last_take_s;
    state == ADCCC_WAIT && conv_done && remain == 8'h01;
  endsequence

  sequence finish_s;
    (state == ADCCC_DONE && launch) ##1 (!launch && state == ADCCC_IDLE);
  endsequence

  launch_sets_a: assert property (@(posedge clock) disable iff (reset)
    launch_write_s |=> launch && state == ADCCC_WAIT)
    else $error("launch bit not set after write");

  launch_held_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_WAIT |-> launch)
    else $error("launch bit dropped during sequence");

  launch_clear_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_DONE |=> !launch && state == ADCCC_IDLE)
    else $error("launch bit not cleared at completion");

  count_load_a: assert property (@(posedge clock) disable iff (reset)
    launch_write_s |=> remain == 8'(1 << $past(avg_code)))
    else $error("wrong measurement count");

  channel_out_a: assert property (@(posedge clock) disable iff (reset)
    setup_wr |=> conv_channel == $past(wr_chan))
    else $error("channel not routed");

  mean_load_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_DONE |=> mean == 8'($past(sum) >> $past(avg_code)))
    else $error("mean wrong");

  low_load_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_DONE |=> lowest_q == $past(run_low)
      && lowest_q <= highest_q)
    else $error("lowest wrong");

  high_load_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_DONE |=> highest_q == $past(run_high))
    else $error("highest wrong");

  seq_end_a: assert property (@(posedge clock) disable iff (reset)
    last_take_s |=> finish_s)
    else $error("sequence did not complete after last measurement");

  early_end_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_WAIT && !(conv_done && remain == 8'h01)
      |=> state == ADCCC_WAIT)
    else $error("sequence ended before its measurement count");

  busy_launch_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_WAIT && start_wr && !conv_done |=> $stable(remain))
    else $error("launch write during a sequence reloaded the count");

  result_hold_a: assert property (@(posedge clock) disable iff (reset)
    state != ADCCC_DONE
      |=> $stable(mean) && $stable(lowest_q) && $stable(highest_q))
    else $error("results changed outside completion");
endmodule
`default_nettype wire

// ==== src/adccc_regs.svh ====
// register offsets, field positions and reset values of the converter control
`ifndef ADCCC_REGS_SVH
`define ADCCC_REGS_SVH
`define ADCCC_OFS_START   8'h50
`define ADCCC_OFS_SETUP   8'h51
`define ADCCC_OFS_MEAN    8'h53
`define ADCCC_OFS_LOWEST  8'h54
`define ADCCC_OFS_HIGHEST 8'h55
`define ADCCC_LAUNCH_BIT  0
`define ADCCC_CHAN_LSB    0
`define ADCCC_CHAN_MSB    2
`define ADCCC_AVG_LSB     3
`define ADCCC_AVG_MSB     5
`define ADCCC_SETUP_MASK  8'h3F
`define ADCCC_RST_BYTE    8'h00
`define ADCCC_LOW_INIT    8'hFF
`define ADCCC_SUM_W       15
`endif

// ==== src/adccc_pkg.sv ====
// types shared by the converter control files
`default_nettype none
package adccc_pkg;
  typedef enum logic [2:0] {
    ADCCC_IDLE = 3'b001,
    ADCCC_WAIT = 3'b010,
    ADCCC_DONE = 3'b100
  } adccc_state_e;
  typedef enum logic [2:0] {
    ADCCC_CH_HAPTIC  = 3'h0,
    ADCCC_CH_MONITOR = 3'h1,
    ADCCC_CH_CHARGER = 3'h3,
    ADCCC_CH_PUMP    = 3'h4,
    ADCCC_CH_BOOST   = 3'h5
  } adccc_chan_e;
endpackage
`default_nettype wire

// ==== src/adccc_stats.sv ====
// running sum, minimum and maximum of one measurement sequence
`default_nettype none
`include "adccc_regs.svh"
module adccc_stats import adccc_pkg::*; #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // control
  input  wire logic                   clear,
  input  wire logic                   sample_valid,
  input  wire logic [DATA_W-1:0]      sample,
  // accumulated values
  output logic [`ADCCC_SUM_W-1:0]     sum,
  output logic [DATA_W-1:0]           lowest,
  output logic [DATA_W-1:0]           highest
);
  logic [`ADCCC_SUM_W-1:0] next_sum;
  logic [DATA_W-1:0]       next_lowest;
  logic [DATA_W-1:0]       next_highest;

  // accumulate or restart
  always_comb begin
    next_sum     = sum;
    next_lowest  = lowest;
    next_highest = highest;
    if (clear) begin
      next_sum     = '0;
      next_lowest  = '1;
      next_highest = '0;
    end else if (sample_valid) begin
      next_sum = sum + `ADCCC_SUM_W'(sample);
      if (sample < lowest) next_lowest = sample;
      if (sample > highest) next_highest = sample;
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (reset) begin
      sum     <= '0;
      lowest  <= '1;
      highest <= '0;
    end else begin
      sum     <= next_sum;
      lowest  <= next_lowest;
      highest <= next_highest;
    end
  end
endmodule
`default_nettype wire

// ==== bench/adc_conversion_control_tb.sv ====
// self-checking bench for the converter launch and averaging block
`default_nettype none
`include "adccc_regs.svh"
module adc_conversion_control_tb import adccc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 0;
  logic       reset = 1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_data, s, lo, hi;
  logic       reg_write, conv_request, conv_done, busy;
  logic [2:0] conv_channel;
  int         fails, checked, avg, n, cnt, sum, g;
  adccc_chan_e chans [5] = '{ADCCC_CH_HAPTIC, ADCCC_CH_MONITOR,
    ADCCC_CH_CHARGER, ADCCC_CH_PUMP, ADCCC_CH_BOOST};
  // 250 MHz clock
  always #2 clock = ~clock;
  adccc_top #(.DATA_W(8)) dut (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_request(conv_request),
    .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_data(conv_data), .busy(busy));
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic cmp(input logic [7:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one-cycle write strobe, launched and dropped off the sampling edge
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    @(negedge clock);
    reg_write = 0;
  endtask
  // read data is combinational, so it is looked at in the same cycle
  task automatic rd(input logic [7:0] a, exp, input string what);
    @(negedge clock);
    reg_addr = a;
    #1 cmp(reg_rdata, exp, what);
  endtask
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    #200000;
    fails++;
    give_verdict;
  end
  // ----------------------------------------
  // main sequence: every averaging depth
  // ----------------------------------------
  initial begin
    reg_addr = 0; reg_wdata = 0; reg_write = 0; conv_done = 0; conv_data = 0;
    void'($urandom(32'hFDED));
    repeat (4) @(posedge clock);
    @(negedge clock) reset = 0;
    foreach (s[i]) rd(8'h50 + 8'(i), 8'h00, "reset value");
    rd(8'h7F, 8'h00, "unmapped");
    cmp({7'h0, conv_request}, 8'h00, "request after reset");
    cmp({7'h0, busy}, 8'h00, "busy after reset");
    cmp({5'h0, conv_channel}, 8'h00, "channel after reset");
    for (avg = 0; avg < 8; avg++) begin
      s = {2'($urandom), avg[2:0], chans[avg % 5]};
      // setup only while idle and never a reserved channel code
      wr(`ADCCC_OFS_SETUP, s);
      rd(`ADCCC_OFS_SETUP, s & 8'h3F, "setup");
      cmp({5'h0, conv_channel}, {5'h0, s[2:0]}, "channel");
      wr(`ADCCC_OFS_START, 8'h01);
      rd(`ADCCC_OFS_START, 8'h01, "launch set");
      wr(`ADCCC_OFS_START, 8'h00);
      wr(`ADCCC_OFS_MEAN, 8'hA5);
      // a second launch while busy must not restart the count
      wr(`ADCCC_OFS_START, 8'h01);
      rd(`ADCCC_OFS_START, 8'h01, "launch held");
      n = 1 << avg; cnt = 0; sum = 0; lo = 8'hFF; hi = 8'h00; g = 0;
      // random gaps between measurements; model counts only taken ones
      while (cnt < n && g < 2000) begin
        @(negedge clock);
        conv_done = ($urandom % 4) != 0;
        conv_data = 8'($urandom);
        if (conv_done && conv_request) begin
          cnt++;
          sum += conv_data;
          if (conv_data < lo) lo = conv_data;
          if (conv_data > hi) hi = conv_data;
        end
        g++;
      end
      // requests that stop short end the run as a failure
      if (cnt < n) begin
        fails++;
        $display("MISMATCH %0t sequence short of measurements", $time);
        give_verdict;
      end
      @(negedge clock) conv_done = 0;
      cmp({7'h0, conv_request}, 8'h00, "no more requests");
      cmp({7'h0, busy}, 8'h01, "busy until loaded");
      g = 0;
      while (busy !== 1'b0 && g < 8) begin
        @(negedge clock);
        g++;
      end
      // strobes outside a sequence must leave the results alone
      conv_done = 1;
      conv_data = 8'h00;
      rd(`ADCCC_OFS_START, 8'h00, "launch cleared");
      rd(`ADCCC_OFS_MEAN, 8'(sum >> avg), "mean");
      rd(`ADCCC_OFS_LOWEST, lo, "lowest");
      rd(`ADCCC_OFS_HIGHEST, hi, "highest");
      @(negedge clock) conv_done = 0;
      $display("test avg %0d done", avg);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
